/* File: rtl/prs_pkg.sv */
package prs_pkg;
  // Sizes
  localparam int NUM_CH = 4;
  localparam int NUM_SLOTS = 11;
  localparam int NV_SLOTS = 4;
  localparam int SET_W = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int SLOT_W = 4;
  localparam int CH_W = 3;
  localparam int STS_W = 8;

  // Present status bit positions
  localparam int STS_CV_BIT = 0;
  localparam int STS_CC_BIT = 1;
  localparam int STS_OV_BIT = 3;
  localparam logic [STS_W-1:0] OV_WEIGHT = 8'h08;

  // Serial poll byte fields
  localparam int SP_ERR_BIT = 5;
  localparam int SP_RQS_BIT = 6;

  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_CHAR = 8'h01;
  localparam logic [7:0] ERR_BAD_NUM = 8'h02;
  localparam logic [7:0] ERR_BAD_STR = 8'h03;
  localparam logic [7:0] ERR_SYNTAX = 8'h04;
  localparam logic [7:0] ERR_RANGE = 8'h05;
  localparam logic [7:0] ERR_NO_QUERY = 8'h06;
  localparam logic [7:0] ERR_STR_LONG = 8'h07;
  localparam logic [7:0] ERR_NUM_BIG = 8'h08;
  localparam logic [7:0] ERR_STR_CHARS = 8'h1C;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ARG = 8'h01;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h02;
  localparam logic [ADDR_W-1:0] REG_SPOLL = 8'h03;
  localparam logic [ADDR_W-1:0] REG_SRQ_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OUT_EN = 8'h05;

  // Reset values
  localparam logic [SET_W-1:0] RST_VOLTAGE_SETPOINT_CMD = 16'h0000;
  localparam logic [SET_W-1:0] RST_CURRENT_LIMIT_CMD = 16'h0000;

  // Command codes written to the command register
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_VOLTAGE_SETPOINT_CMD = 4'h1,
    OP_CURRENT_LIMIT_CMD = 4'h2,
    OP_VOLTAGE_SETPOINT_CMD_Q = 4'h3,
    OP_CURRENT_LIMIT_CMD_Q = 4'h4,
    OP_STS_Q = 4'h5,
    OP_FAULT_Q = 4'h6,
    OP_MASK = 4'h7,
    OP_SRQ = 4'h8,
    OP_OUT = 4'h9,
    OP_OV_REARM = 4'hA,
    OP_SAVE = 4'hB,
    OP_RESTORE = 4'hC,
    OP_CLEAR = 4'hD,
    OP_ERR_Q = 4'hE,
    OP_MASK_Q = 4'hF
  } prs_op_t;
endpackage

/* File: rtl/prs_mem_if.sv */
`timescale 1ns/100ps
interface prs_mem_if;
  import prs_pkg::*;
  logic we;
  logic [SLOT_W-1:0] addr;
  logic [2*NUM_CH*SET_W-1:0] wdata;
  logic [2*NUM_CH*SET_W-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

/* File: rtl/prs_state_mem.sv */
`timescale 1ns/100ps
module prs_state_mem #(
  parameter int DEPTH = prs_pkg::NUM_SLOTS
) (
  input wire logic i_clk,
  prs_mem_if.mem mem
);
  import prs_pkg::*;
  logic [2*NUM_CH*SET_W-1:0] store_r [DEPTH];
  logic [2*NUM_CH*SET_W-1:0] rdata_r;

  // Snapshot array; no reset, slot contents are undefined until saved
  always_ff @(posedge i_clk) begin
    if (mem.we) begin
      store_r[mem.addr] <= mem.wdata;
    end
    rdata_r <= store_r[mem.addr];
  end
  assign mem.rdata = rdata_r;
endmodule // prs_state_mem

/* File: rtl/prs_core.sv */
`timescale 1ns/100ps
module prs_core #(
  parameter int CHANNELS = prs_pkg::NUM_CH
) (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic [prs_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [prs_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [prs_pkg::DATA_W-1:0] O_RDATA,
  input wire logic [prs_pkg::NUM_CH-1:0] I_CV_MODE,
  input wire logic [prs_pkg::NUM_CH-1:0] I_CC_MODE,
  input wire logic [prs_pkg::NUM_CH-1:0] I_OV_TRIP,
  input wire logic [7:0] I_PARSE_ERR,
  input wire logic I_PARSE_ERR_VALID,
  output logic [prs_pkg::NUM_CH-1:0] O_OUT_EN,
  output logic [prs_pkg::NUM_CH-1:0] O_OV_REARM,
  output logic [prs_pkg::NUM_CH*prs_pkg::SET_W-1:0] O_VOLTAGE_SETPOINT_CMD,
  output logic [prs_pkg::NUM_CH*prs_pkg::SET_W-1:0] O_CURRENT_LIMIT_CMD,
  output logic O_SRQ,
  output logic O_ERR_LAMP
);
  import prs_pkg::*;

  prs_mem_if mif ();

  // Settings and output control
  logic [NUM_CH*SET_W-1:0] voltage_setpoint_cmd_r, voltage_setpoint_cmd_nxt, current_limit_cmd_r, current_limit_cmd_nxt;
  logic [NUM_CH-1:0] out_en_r, out_en_nxt, rearm_r, rearm_nxt;
  logic [NUM_CH-1:0] ov_latch_r, ov_latch_nxt;

  // Per-output mask, fault and live status
  logic [STS_W-1:0] mask_r [NUM_CH];
  logic [STS_W-1:0] mask_nxt [NUM_CH];
  logic [STS_W-1:0] fault_r [NUM_CH];
  logic [STS_W-1:0] fault_nxt [NUM_CH];
  logic [STS_W-1:0] sts [NUM_CH];

  // Poll summary, request setting and error state
  logic [NUM_CH-1:0] fau_r, fau_nxt;
  logic [1:0] srq_mode_r, srq_mode_nxt;
  logic [7:0] err_code_r, err_code_nxt;
  logic err_flag_r, err_flag_nxt;

  // Host registers and recall strobe
  logic [DATA_W-1:0] arg_r, arg_nxt, result_r, result_nxt, rdata_r, rdata_nxt;
  logic restore_r, restore_nxt;

  // Decode and combinational status
  logic [NUM_CH-1:0] fault_any;
  logic [7:0] spoll;
  logic [3:0] op;
  logic [CH_W-1:0] ch;
  logic [1:0] ch_idx;
  logic cmd_wr;

  // Channel check shared by every channel-bearing command
  // channels one to fitted
  function automatic logic ch_ok(input logic [CH_W-1:0] c);
    ch_ok = (c >= 3'h1) && (c <= CH_W'(CHANNELS));
  endfunction

  // Command word fields; value byte decoded per command
  assign op = I_WDATA[15:12];
  assign ch = I_WDATA[10:8];
  assign ch_idx = 2'(ch - 3'h1);
  assign cmd_wr = I_WR && (I_ADDR == REG_CMD);

  // Per-output status and fault compare
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_sts
      always_comb begin
        sts[g] = '0;
        sts[g][STS_CV_BIT] = I_CV_MODE[g];
        sts[g][STS_CC_BIT] = I_CC_MODE[g];
        sts[g][STS_OV_BIT] = ov_latch_r[g];
      end
      assign fault_any[g] = |(sts[g] & mask_r[g]);
    end
  endgenerate

  always_comb begin
    spoll = '0;
    spoll[NUM_CH-1:0] = fau_r;
    spoll[SP_ERR_BIT] = err_flag_r;
    spoll[SP_RQS_BIT] = O_SRQ;
  end

  // Slot field always addresses memory, so a recall has data a cycle later
  assign mif.addr = I_WDATA[SLOT_W-1:0];
  assign mif.wdata = {current_limit_cmd_r, voltage_setpoint_cmd_r};
  assign mif.we = cmd_wr && (op == OP_SAVE) && !I_PARSE_ERR_VALID &&
                  (I_WDATA[SLOT_W-1:0] < SLOT_W'(NUM_SLOTS));

  // eleven snapshot slots
  // Keeping slots 0-3 through power loss is up to the memory macro
  prs_state_mem #(.DEPTH(NUM_SLOTS)) u_mem (
    .i_clk(I_MCLK),
    .mem(mif.mem)
  );

  // Command execution and status next state
  always_comb begin
    voltage_setpoint_cmd_nxt = voltage_setpoint_cmd_r;
    current_limit_cmd_nxt = current_limit_cmd_r;
    out_en_nxt = out_en_r;
    rearm_nxt = '0;
    ov_latch_nxt = ov_latch_r | I_OV_TRIP;
    mask_nxt = mask_r;
    fault_nxt = fault_r;
    fau_nxt = fau_r;
    srq_mode_nxt = srq_mode_r;
    err_code_nxt = err_code_r;
    err_flag_nxt = err_flag_r;
    arg_nxt = arg_r;
    result_nxt = result_r;
    restore_nxt = 1'b0;
    rdata_nxt = '0;
    // fault latch, SRQ independent
    // Fault registers latch unmasked conditions until read
    for (int k = 0; k < NUM_CH; k++) begin
      fault_nxt[k] = fault_r[k] | (sts[k] & mask_r[k]);
    end
    // Summary bits hold unless a fault read or the clear command clears them
    for (int k = 0; k < NUM_CH; k++) begin
      fau_nxt[k] = fau_r[k];
    end

    if (I_WR && I_ADDR == REG_ARG) begin
      arg_nxt = I_WDATA;
    end
    if (I_WR && I_ADDR == REG_SRQ_MODE) begin
      srq_mode_nxt = I_WDATA[1:0];
    end
    if (cmd_wr) begin
      if (I_PARSE_ERR_VALID) begin
        err_code_nxt = I_PARSE_ERR;
        err_flag_nxt = 1'b1;
      end else if ((op inside {OP_VOLTAGE_SETPOINT_CMD, OP_CURRENT_LIMIT_CMD, OP_VOLTAGE_SETPOINT_CMD_Q, OP_CURRENT_LIMIT_CMD_Q, OP_STS_Q,
                    OP_FAULT_Q, OP_MASK, OP_OUT, OP_OV_REARM, OP_MASK_Q}) && !ch_ok(ch)) begin
        err_code_nxt = ERR_RANGE;
        err_flag_nxt = 1'b1;
      end else if ((op inside {OP_SAVE, OP_RESTORE}) &&
                   (I_WDATA[SLOT_W-1:0] >= SLOT_W'(NUM_SLOTS))) begin
        err_code_nxt = ERR_RANGE;
        err_flag_nxt = 1'b1;
      end else begin
        case (prs_op_t'(op))
          OP_VOLTAGE_SETPOINT_CMD: voltage_setpoint_cmd_nxt[ch_idx*SET_W +: SET_W] = arg_r;
          OP_CURRENT_LIMIT_CMD: current_limit_cmd_nxt[ch_idx*SET_W +: SET_W] = arg_r;
          // each query overwrites result; buffered answer
          OP_VOLTAGE_SETPOINT_CMD_Q: result_nxt = voltage_setpoint_cmd_r[ch_idx*SET_W +: SET_W];
          OP_CURRENT_LIMIT_CMD_Q: result_nxt = current_limit_cmd_r[ch_idx*SET_W +: SET_W];
          OP_STS_Q: result_nxt = DATA_W'(sts[ch_idx]);
          OP_MASK_Q: result_nxt = DATA_W'(mask_r[ch_idx]);
          OP_FAULT_Q: begin
            result_nxt = DATA_W'(fault_r[ch_idx]);
            fault_nxt[ch_idx] = sts[ch_idx] & mask_r[ch_idx];
            fau_nxt[ch_idx] = 1'b0;
          end
          OP_MASK: mask_nxt[ch_idx] = I_WDATA[STS_W-1:0];
          OP_SRQ: srq_mode_nxt = I_WDATA[1:0];
          OP_OUT: out_en_nxt[ch_idx] = I_WDATA[0];
          OP_OV_REARM: begin
            ov_latch_nxt[ch_idx] = I_OV_TRIP[ch_idx];
            rearm_nxt[ch_idx] = 1'b1;
          end
          OP_RESTORE: restore_nxt = 1'b1;
          // error query returns code and clears it
          OP_ERR_Q: begin
            result_nxt = DATA_W'(err_code_r);
            err_code_nxt = ERR_NONE;
            err_flag_nxt = 1'b0;
          end
          OP_CLEAR: begin
            voltage_setpoint_cmd_nxt = {NUM_CH{RST_VOLTAGE_SETPOINT_CMD}};
            current_limit_cmd_nxt = {NUM_CH{RST_CURRENT_LIMIT_CMD}};
            out_en_nxt = '1;
            ov_latch_nxt = I_OV_TRIP;
            rearm_nxt = '1;
            for (int k = 0; k < NUM_CH; k++) begin
              mask_nxt[k] = '0;
              fault_nxt[k] = '0;
            end
            fau_nxt = '0;
            srq_mode_nxt = 2'h0;
          end
          default: ;
        endcase
      end
    end

    // Hardware fault raise takes priority over any clear
    fau_nxt = fau_nxt | fault_any;
    // Recall lands last and overrides same-cycle setpoint and limit writes
    if (restore_r) begin
      {current_limit_cmd_nxt, voltage_setpoint_cmd_nxt} = mif.rdata;
    end
    // Read port is zero outside the read slot
    if (I_RD) begin
      case (I_ADDR)
        REG_RESULT: rdata_nxt = result_r;
        REG_SPOLL: rdata_nxt = DATA_W'(spoll);
        REG_SRQ_MODE: rdata_nxt = DATA_W'(srq_mode_r);
        REG_OUT_EN: rdata_nxt = DATA_W'(out_en_r);
        REG_ARG: rdata_nxt = arg_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // State registers
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      // Power-on settings with every output enabled
      voltage_setpoint_cmd_r <= {NUM_CH{RST_VOLTAGE_SETPOINT_CMD}};
      current_limit_cmd_r <= {NUM_CH{RST_CURRENT_LIMIT_CMD}};
      out_en_r <= '1;
      rearm_r <= '0;
      ov_latch_r <= '0;
      for (int k = 0; k < NUM_CH; k++) begin
        mask_r[k] <= '0;
        fault_r[k] <= '0;
      end
      // Request and error state idle
      fau_r <= '0;
      srq_mode_r <= 2'h0;
      err_code_r <= ERR_NONE;
      err_flag_r <= 1'b0;
      // Host registers cleared
      arg_r <= '0;
      result_r <= '0;
      restore_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      // Settings and enables
      voltage_setpoint_cmd_r <= voltage_setpoint_cmd_nxt;
      current_limit_cmd_r <= current_limit_cmd_nxt;
      out_en_r <= out_en_nxt;
      rearm_r <= rearm_nxt;
      ov_latch_r <= ov_latch_nxt;
      // Status, request and error state
      mask_r <= mask_nxt;
      fault_r <= fault_nxt;
      fau_r <= fau_nxt;
      srq_mode_r <= srq_mode_nxt;
      err_code_r <= err_code_nxt;
      err_flag_r <= err_flag_nxt;
      // Host registers and read port
      arg_r <= arg_nxt;
      result_r <= result_nxt;
      restore_r <= restore_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // fault SRQ; error SRQ; held until cleared
  assign O_SRQ = ((srq_mode_r == 2'h1) && (|fau_r)) ||
                 ((srq_mode_r == 2'h2 || srq_mode_r == 2'h3) && err_flag_r);
  assign O_ERR_LAMP = err_flag_r;
  // Data outputs straight from flops
  assign O_OUT_EN = out_en_r;
  assign O_OV_REARM = rearm_r;
  assign O_VOLTAGE_SETPOINT_CMD = voltage_setpoint_cmd_r;
  assign O_CURRENT_LIMIT_CMD = current_limit_cmd_r;
  assign O_RDATA = rdata_r;
endmodule // prs_core

/* File: test/prs_core_chk.sv */
`timescale 1ns/100ps
module prs_core_chk
  import prs_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic [prs_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [prs_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_PARSE_ERR_VALID,
  input wire logic [prs_pkg::DATA_W-1:0] O_RDATA,
  input wire logic [prs_pkg::NUM_CH-1:0] O_OUT_EN,
  input wire logic [prs_pkg::NUM_CH-1:0] O_OV_REARM,
  input wire logic [prs_pkg::NUM_CH*prs_pkg::SET_W-1:0] O_VOLTAGE_SETPOINT_CMD,
  input wire logic [prs_pkg::NUM_CH*prs_pkg::SET_W-1:0] O_CURRENT_LIMIT_CMD,
  input wire logic O_ERR_LAMP
);
  logic cmd_wr, ok, rst_wr, rearm_cmd;
  logic [3:0] op;
  logic [2:0] ch;
  logic [3:0] chm;
  // Command decode; a restore lands late, so it is masked out nearby
  always_comb begin
    cmd_wr = I_WR && (I_ADDR == REG_CMD);
    op = I_WDATA[15:12];
    ch = I_WDATA[10:8];
    ok = cmd_wr && (ch != 3'h0) && (ch <= CHANNELS) && !I_PARSE_ERR_VALID;
    chm = (ch != 3'h0) ? (4'h1 << (ch - 3'h1)) : 4'h0;
    rst_wr = cmd_wr && (op == OP_RESTORE);
    rearm_cmd = (ok && (op == OP_OV_REARM)) ||
                (cmd_wr && !I_PARSE_ERR_VALID && (op == OP_CLEAR));
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);
  // Argument then setpoint command, one idle cycle apart
  sequence s_arg_voltage_setpoint_cmd;
    I_WR && (I_ADDR == REG_ARG) ##2 ok && (op == OP_VOLTAGE_SETPOINT_CMD) && (ch == 3'h1) && !$past(rst_wr);
  endsequence
  sequence s_pulse(logic [3:0] m);
    (O_OV_REARM == m) ##1 (O_OV_REARM == 4'h0);
  endsequence
  a_rdata_quiet: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
    else $error("read data not zero outside read slot");
  a_voltage_setpoint_cmd_apply: assert property (s_arg_voltage_setpoint_cmd |=> O_VOLTAGE_SETPOINT_CMD[15:0] == $past(I_WDATA, 3))
    else $error("setpoint not applied");
  a_err_noexec: assert property (cmd_wr && I_PARSE_ERR_VALID && !$past(rst_wr) |=>
    $stable(O_VOLTAGE_SETPOINT_CMD) && $stable(O_CURRENT_LIMIT_CMD) && $stable(O_OUT_EN)) else $error("bad command ran");
  a_err_lamp: assert property (cmd_wr && I_PARSE_ERR_VALID |=> O_ERR_LAMP)
    else $error("lamp not lit on error");
  a_lamp_holds: assert property (O_ERR_LAMP && !I_WR |=> O_ERR_LAMP)
    else $error("lamp dropped with no command");
  a_range_err: assert property (cmd_wr && (op == OP_VOLTAGE_SETPOINT_CMD) && (ch == 3'h0 || ch > CHANNELS)
    && !$past(rst_wr) |=> O_ERR_LAMP && $stable(O_VOLTAGE_SETPOINT_CMD)) else $error("bad channel taken");
  a_out_off: assert property (ok && (op == OP_OUT) && !I_WDATA[0] |=>
    (O_OUT_EN & $past(chm)) == 4'h0) else $error("output not disabled");
  a_rearm_pulse: assert property (ok && (op == OP_OV_REARM) |=> s_pulse($past(chm)))
    else $error("rearm pulse wrong");
  a_rearm_cause: assert property (O_OV_REARM != 4'h0 |-> $past(rearm_cmd))
    else $error("rearm without command");
  a_clear_state: assert property (ok && (op == OP_CLEAR) && !$past(rst_wr) |=>
    O_OUT_EN == 4'hF && O_VOLTAGE_SETPOINT_CMD == {NUM_CH{RST_VOLTAGE_SETPOINT_CMD}} && O_OV_REARM == 4'hF)
    else $error("clear state wrong");
endmodule // prs_core_chk

bind prs_core prs_core_chk #(.CHANNELS(CHANNELS)) prs_core_chk_i (.I_MCLK(I_MCLK),
  .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .I_PARSE_ERR_VALID(I_PARSE_ERR_VALID), .O_RDATA(O_RDATA), .O_OUT_EN(O_OUT_EN),
  .O_OV_REARM(O_OV_REARM), .O_VOLTAGE_SETPOINT_CMD(O_VOLTAGE_SETPOINT_CMD), .O_CURRENT_LIMIT_CMD(O_CURRENT_LIMIT_CMD), .O_ERR_LAMP(O_ERR_LAMP));

/* File: test/prs_host.sv */
`timescale 1ns/100ps
module prs_host (
  input wire logic i_clk,
  input wire logic [prs_pkg::DATA_W-1:0] i_rdata,
  output logic [prs_pkg::ADDR_W-1:0] o_addr,
  output logic [prs_pkg::DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // Idle bus from time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
endmodule // prs_host

/* File: test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import prs_pkg::*;
  logic clk, rst_n, wr, rd, pev, srq, lamp;
  logic [7:0] addr, perr;
  logic [15:0] wdata, rdata;
  logic [3:0] cv, cc, ov, oen, rearm;
  logic [63:0] voltage_setpoint_cmd, current_limit_cmd;
  int errors, n_checks, cycles;
  logic [7:0] codes [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h1C};
  prs_core #(.CHANNELS(4)) prs_core_i (.I_MCLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CV_MODE(cv), .I_CC_MODE(cc),
    .I_OV_TRIP(ov), .I_PARSE_ERR(perr), .I_PARSE_ERR_VALID(pev), .O_OUT_EN(oen),
    .O_OV_REARM(rearm), .O_VOLTAGE_SETPOINT_CMD(voltage_setpoint_cmd), .O_CURRENT_LIMIT_CMD(current_limit_cmd), .O_SRQ(srq), .O_ERR_LAMP(lamp));
  prs_host prs_host_i (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [2:0] ch, input logic [7:0] v);
    prs_host_i.wr(REG_CMD, {op, 1'b0, ch, v});
  endtask
  task automatic set(input logic [3:0] op, input logic [2:0] ch, input logic [15:0] a);
    prs_host_i.wr(REG_ARG, a);
    cmd(op, ch, 8'h00);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] d;
    prs_host_i.rd(a, d);
    chk(64'(d & m), 64'(e));
  endtask
  task automatic query(input logic [3:0] op, input logic [2:0] ch, input logic [15:0] m,
                       input logic [15:0] e);
    cmd(op, ch, 8'h00);
    rdchk(REG_RESULT, m, e);
  endtask
  // Overvoltage fault through mask, poll and service request
  task automatic t_fault;
    cmd(OP_CLEAR, 1, 8'h00);
    cmd(OP_MASK, 1, 8'h08);
    cmd(OP_SRQ, 1, 8'h01);
    rdchk(REG_SRQ_MODE, 16'h0003, 16'h0001);
    @(posedge clk) ov <= 4'h1;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (srq === 1'b1) break;
    end
    chk(64'(srq), 64'h1);
    rdchk(REG_SPOLL, 16'h000F, 16'h0001);
    @(posedge clk) ov <= 4'h0;
    cmd(OP_OUT, 1, 8'h00);
    cmd(OP_OV_REARM, 1, 8'h00);
    #1 chk(64'(oen[0]), 64'h0);
    query(OP_MASK_Q, 1, 16'h00FF, 16'h0008);
    query(OP_FAULT_Q, 1, 16'h0008, 16'h0008);
    rdchk(REG_SPOLL, 16'h000F, 16'h0000);
    #1 chk(64'(srq), 64'h0);
  endtask
  // Settings, readback and status
  task automatic t_setting;
    set(OP_VOLTAGE_SETPOINT_CMD, 1, 16'h1234);
    set(OP_CURRENT_LIMIT_CMD, 1, 16'h0567);
    #1 chk(64'(voltage_setpoint_cmd[15:0]), 64'h1234);
    rdchk(REG_ARG, 16'hFFFF, 16'h0567);
    cmd(OP_VOLTAGE_SETPOINT_CMD_Q, 1, 8'h00);
    query(OP_CURRENT_LIMIT_CMD_Q, 1, 16'hFFFF, 16'h0567);
    @(posedge clk) begin
      cv <= 4'h1;
      cc <= 4'h2;
    end
    query(OP_STS_Q, 1, 16'h000B, 16'h0001);
    query(OP_STS_Q, 2, 16'h000B, 16'h0002);
    rdchk(REG_OUT_EN, 16'h000F, 16'h000E);
    rdchk(8'h20, 16'hFFFF, 16'h0000);
  endtask
  // Every error code, cycling through the four request settings
  task automatic t_errors;
    for (int i = 0; i < 9; i++) begin
      cmd(OP_SRQ, 1, 8'(i % 4));
      prs_host_i.wr(REG_ARG, 16'hBEEF);
      @(posedge clk) begin
        perr <= codes[i];
        pev <= 1'b1;
      end
      cmd(OP_VOLTAGE_SETPOINT_CMD, 1, 8'h00);
      pev <= 1'b0;
      #1 chk(64'(voltage_setpoint_cmd[15:0]), 64'h1234);
      chk(64'(lamp), 64'h1);
      chk(64'(srq), 64'(i[1]));
      rdchk(REG_SPOLL, 16'h0020, 16'h0020);
      query(OP_ERR_Q, 1, 16'h00FF, 16'(codes[i]));
      #1 chk(64'(lamp), 64'h0);
    end
    query(OP_ERR_Q, 1, 16'h00FF, 16'h0000);
    cmd(OP_SRQ, 1, 8'h00);
    prs_host_i.wr(REG_SRQ_MODE, 16'h0003);
    rdchk(REG_SRQ_MODE, 16'h0003, 16'h0003);
    cmd(OP_VOLTAGE_SETPOINT_CMD, 5, 8'h00);
    #1 chk(64'(srq), 64'h1);
    query(OP_ERR_Q, 1, 16'h00FF, 16'h0005);
    chk(64'(voltage_setpoint_cmd[15:0]), 64'h1234);
  endtask
  // Snapshots taken, recalled out of order, bad slot refused
  task automatic t_store;
    set(OP_VOLTAGE_SETPOINT_CMD, 2, 16'h0222);
    cmd(OP_SAVE, 1, 8'h03);
    set(OP_VOLTAGE_SETPOINT_CMD, 1, 16'h0111);
    set(OP_CURRENT_LIMIT_CMD, 2, 16'h0099);
    cmd(OP_SAVE, 1, 8'h0A);
    cmd(OP_CLEAR, 1, 8'h00);
    cmd(OP_RESTORE, 1, 8'h0A);
    @(posedge clk);
    #1 chk({voltage_setpoint_cmd[31:0], current_limit_cmd[31:0]}, 64'h0222_0111_0099_0567);
    cmd(OP_RESTORE, 1, 8'h03);
    @(posedge clk);
    #1 chk({voltage_setpoint_cmd[31:0], current_limit_cmd[31:0]}, 64'h0222_1234_0000_0567);
    cmd(OP_RESTORE, 1, 8'h0B);
    query(OP_ERR_Q, 1, 16'h00FF, 16'h0005);
  endtask
  // Clear brings outputs back on at initial settings
  task automatic t_clear;
    cmd(OP_OUT, 2, 8'h00);
    cmd(OP_CLEAR, 1, 8'h00);
    #1 chk(64'(oen), 64'hF);
    chk(voltage_setpoint_cmd, 64'h0);
  endtask
  // Reset, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    cv = 4'h0;
    cc = 4'h0;
    ov = 4'h0;
    perr = 8'h00;
    pev = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_fault();
    t_setting();
    t_errors();
    t_store();
    t_clear();
    summarize();
  end
endmodule // tb_top
